// >>> rtl/mepc_regs.sv
// Purpose: Motion event, power and interrupt register slice
// Assumes: Serial engine presents byte strobes; detectors send one-cycle events
// Notes: Reads answer one cycle after reg_rd
`timescale 1ns/10ps
`include "mepc_map.svh"
module mepc_regs #(
  parameter int FALL_STEP_CYC = `MEPC_FALL_STEP_MS * (`MEPC_NS_PER_MS / `MEPC_CLK_NS),
  parameter int WAKE_CYC = `MEPC_WAKE_BASE_MS * (`MEPC_NS_PER_MS / `MEPC_CLK_NS)
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic data_read,
  input wire logic evt_sample,
  input wire logic evt_watermark,
  input wire logic evt_overrun,
  input wire logic evt_single_tap,
  input wire logic evt_double_tap,
  input wire logic knock_between_above,
  input wire logic [2:0] tap_axis_hit,
  input wire logic evt_activity,
  input wire logic [2:0] act_axis_hit,
  input wire logic [2:0] act_axis_en,
  input wire logic evt_inactivity,
  input wire logic fall_below,
  output logic irq_pin_a,
  output logic irq_pin_b,
  output logic [2:0] tap_axis_en,
  output logic double_knock_reject,
  output logic low_power,
  output logic [3:0] rate_code,
  output logic measure,
  output logic act_run,
  output logic inact_run,
  output logic fifo_wr_en,
  output logic doze_tick,
  output logic self_test,
  output logic clip_en
);
  mepc_ctl_if ctl ();

  logic [7:0] fall_duration, tap_axis_select, output_rate_control, power_state_control;
  logic [7:0] irq_enable_mask, irq_pin_routing, irq_event_flags, output_format_control;
  logic [7:0] next_fall, next_tap, next_rate, next_pwr, next_ien, next_imap, next_flags, next_fmt;
  logic [2:0] act_src, tap_src, next_act_src, next_tap_src;
  logic [7:0] event_axis_status, rd_mux, next_rdata, hits;
  logic next_pin_a, next_pin_b, next_clip, wr, src_rd, dbl_ok, tap_any;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  mepc_fall_timer #(.STEP_CYC(FALL_STEP_CYC)) u_fall (
    .mclk(mclk),
    .nrst(nrst),
    .ctl(ctl.fall)
  );
  mepc_power_state_control #(.WAKE_CYC(WAKE_CYC)) u_pwr (
    .mclk(mclk),
    .nrst(nrst),
    .ctl(ctl.pwr)
  );

  assign ctl.fall_below = fall_below;
  assign ctl.fall_code = fall_duration;
  assign ctl.measure = power_state_control[`MEPC_PWR_MEAS];
  assign ctl.link_en = power_state_control[`MEPC_PWR_LINK];
  assign ctl.auto_sleep = power_state_control[`MEPC_PWR_AUTO];
  assign ctl.sleep_req = power_state_control[`MEPC_PWR_SLEEP];
  assign ctl.wake_code = power_state_control[1:0];
  assign ctl.act_fn_en = irq_enable_mask[`MEPC_I_ACT];
  assign ctl.inact_fn_en = irq_enable_mask[`MEPC_I_INACT];
  assign ctl.act_hit = hits[`MEPC_I_ACT];
  assign ctl.inact_hit = hits[`MEPC_I_INACT];
  assign act_run = ctl.act_run;
  assign inact_run = ctl.inact_run;
  assign fifo_wr_en = ctl.awake;
  assign doze_tick = ctl.doze_tick;

  // ----------------------------------------
  // Configuration outputs
  // ----------------------------------------
  assign tap_axis_en = tap_axis_select[2:0];
  assign double_knock_reject = tap_axis_select[`MEPC_TAP_SUPP];
  assign low_power = output_rate_control[`MEPC_LOW_PWR];
  assign rate_code = output_rate_control[3:0];
  assign measure = power_state_control[`MEPC_PWR_MEAS];
  assign self_test = output_format_control[`MEPC_FMT_TEST];

  // ----------------------------------------
  // Event acceptance
  // ----------------------------------------
  assign wr = reg_wr;
  assign src_rd = reg_rd && reg_addr == `MEPC_A_ISRC;
  // A double knock with over-threshold noise between knocks is dropped
  assign dbl_ok = ~(tap_axis_select[`MEPC_TAP_SUPP] & knock_between_above);
  assign tap_any = hits[`MEPC_I_SINGLE] | hits[`MEPC_I_DOUBLE];

  always_comb begin
    hits = '0;
    hits[`MEPC_I_READY] = evt_sample & ctl.awake;
    hits[`MEPC_I_WMARK] = evt_watermark;
    hits[`MEPC_I_OVR] = evt_overrun;
    hits[`MEPC_I_SINGLE] = evt_single_tap & irq_enable_mask[`MEPC_I_SINGLE] & ctl.awake;
    hits[`MEPC_I_DOUBLE] = evt_double_tap & irq_enable_mask[`MEPC_I_DOUBLE] & ctl.awake & dbl_ok;
    hits[`MEPC_I_ACT] = evt_activity & irq_enable_mask[`MEPC_I_ACT] & ctl.act_run;
    hits[`MEPC_I_INACT] = evt_inactivity & irq_enable_mask[`MEPC_I_INACT] & ctl.inact_run;
    hits[`MEPC_I_FALL] = ctl.fall_evt & irq_enable_mask[`MEPC_I_FALL];
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_comb begin
    next_fall = fall_duration;
    next_tap = tap_axis_select;
    next_rate = output_rate_control;
    next_pwr = power_state_control;
    next_ien = irq_enable_mask;
    next_imap = irq_pin_routing;
    next_fmt = output_format_control;
    next_clip = clip_en;
    if (wr) begin
      unique case (reg_addr)
        `MEPC_A_FALL: next_fall = reg_wdata;
        `MEPC_A_TAP: next_tap = reg_wdata & `MEPC_M_TAP;
        `MEPC_A_RATE: next_rate = reg_wdata & `MEPC_M_RATE;
        `MEPC_A_PWR: next_pwr = reg_wdata & `MEPC_M_PWR;
        `MEPC_A_IEN: next_ien = reg_wdata;
        `MEPC_A_IMAP: next_imap = reg_wdata;
        `MEPC_A_FMT: begin
          next_fmt = reg_wdata & `MEPC_M_FMT;
          next_clip = reg_wdata[1:0] != `MEPC_RANGE_16G;
        end
        default: ;
      endcase
    end
    // Clears first so that a same-cycle event wins
    next_flags = irq_event_flags;
    if (src_rd)
      next_flags = next_flags & ~`MEPC_M_DET;
    if (data_read)
      next_flags = next_flags & ~`MEPC_M_FIFO;
    next_flags = next_flags | hits;
    // Axis flags hold the last event's axes, masked by current participation
    next_act_src = hits[`MEPC_I_ACT] ? (act_axis_hit & act_axis_en) : act_src;
    next_tap_src = tap_any ? (tap_axis_hit & tap_axis_select[2:0]) : tap_src;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fall_duration <= `MEPC_RST_ZERO;
      tap_axis_select <= `MEPC_RST_ZERO;
      output_rate_control <= `MEPC_RST_RATE;
      power_state_control <= `MEPC_RST_ZERO;
      irq_enable_mask <= `MEPC_RST_ZERO;
      irq_pin_routing <= `MEPC_RST_ZERO;
      irq_event_flags <= `MEPC_RST_ZERO;
      output_format_control <= `MEPC_RST_ZERO;
      clip_en <= 1'b1;
      act_src <= '0;
      tap_src <= '0;
    end else begin
      fall_duration <= next_fall;
      tap_axis_select <= next_tap;
      output_rate_control <= next_rate;
      power_state_control <= next_pwr;
      irq_enable_mask <= next_ien;
      irq_pin_routing <= next_imap;
      irq_event_flags <= next_flags;
      output_format_control <= next_fmt;
      clip_en <= next_clip;
      act_src <= next_act_src;
      tap_src <= next_tap_src;
    end
  end

  // ----------------------------------------
  // Read path and pins
  // ----------------------------------------
  assign event_axis_status = {1'b0, act_src, ctl.asleep, tap_src};

  always_comb begin
    unique case (reg_addr)
      `MEPC_A_FALL: rd_mux = fall_duration;
      `MEPC_A_TAP: rd_mux = tap_axis_select;
      `MEPC_A_EVST: rd_mux = event_axis_status;
      `MEPC_A_RATE: rd_mux = output_rate_control;
      `MEPC_A_PWR: rd_mux = power_state_control;
      `MEPC_A_IEN: rd_mux = irq_enable_mask;
      `MEPC_A_IMAP: rd_mux = irq_pin_routing;
      `MEPC_A_ISRC: rd_mux = irq_event_flags;
      `MEPC_A_FMT: rd_mux = output_format_control;
      default: rd_mux = `MEPC_RST_ZERO;
    endcase
    next_rdata = reg_rd ? rd_mux : reg_rdata;
    // Pins follow the stored flags; polarity applies to both
    next_pin_a = |(irq_event_flags & irq_enable_mask & ~irq_pin_routing)
      ^ output_format_control[`MEPC_FMT_INV];
    next_pin_b = |(irq_event_flags & irq_enable_mask & irq_pin_routing)
      ^ output_format_control[`MEPC_FMT_INV];
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= `MEPC_RST_ZERO;
      irq_pin_a <= 1'b0;
      irq_pin_b <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      irq_pin_a <= next_pin_a;
      irq_pin_b <= next_pin_b;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence src_read_quiet;
    src_rd && !(|(hits & `MEPC_M_DET));
  endsequence
  sequence src_read_seen;
    ##1 (irq_event_flags & `MEPC_M_DET) == `MEPC_RST_ZERO;
  endsequence
  src_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    src_read_quiet |-> src_read_seen)
    else $error("detector flags survived source read");
  data_clear_a: assert property (@(posedge mclk) disable iff (!nrst)
    data_read && !(|(hits & `MEPC_M_FIFO)) |=> (irq_event_flags & `MEPC_M_FIFO) == `MEPC_RST_ZERO)
    else $error("data flags survived data read");
  set_wins_a: assert property (@(posedge mclk) disable iff (!nrst)
    hits[`MEPC_I_OVR] |=> irq_event_flags[`MEPC_I_OVR])
    else $error("overflow event lost");
  pin_route_a: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 irq_pin_b == ($past(|(irq_event_flags & irq_enable_mask & irq_pin_routing))
      ^ $past(output_format_control[`MEPC_FMT_INV])))
    else $error("second pin mismatch");
  pin_idle_a: assert property (@(posedge mclk) disable iff (!nrst)
    irq_enable_mask == `MEPC_RST_ZERO ##1 irq_enable_mask == `MEPC_RST_ZERO
    |-> irq_pin_a == output_format_control[`MEPC_FMT_INV] || $changed(output_format_control))
    else $error("pin active without enabled flag");
  tap_axes_a: assert property (@(posedge mclk) disable iff (!nrst)
    tap_any |=> tap_src == $past(tap_axis_hit & tap_axis_select[2:0]))
    else $error("tap source not masked by participation");
  knock_rej_a: assert property (@(posedge mclk) disable iff (!nrst)
    tap_axis_select[`MEPC_TAP_SUPP] && knock_between_above |-> !hits[`MEPC_I_DOUBLE])
    else $error("double knock accepted through noise");
  doze_status_a: assert property (@(posedge mclk) disable iff (!nrst)
    reg_rd && reg_addr == `MEPC_A_EVST |=> reg_rdata[`MEPC_ST_ASLEEP] == $past(ctl.asleep))
    else $error("doze status bit wrong");
  clip_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr && reg_addr == `MEPC_A_FMT |=> clip_en == ($past(reg_wdata[1:0]) != `MEPC_RANGE_16G))
    else $error("clipping not tied to range");
  act_axes_a: assert property (@(posedge mclk) disable iff (!nrst)
    hits[`MEPC_I_ACT] |=> act_src == $past(act_axis_hit & act_axis_en))
    else $error("activity source not masked by participation");
  axis_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !hits[`MEPC_I_ACT] && !tap_any |=> $stable(act_src) && $stable(tap_src))
    else $error("axis source changed without event");
  pin_a_route_a: assert property (@(posedge mclk) disable iff (!nrst)
    ##1 irq_pin_a == ($past(|(irq_event_flags & irq_enable_mask & ~irq_pin_routing))
      ^ $past(output_format_control[`MEPC_FMT_INV])))
    else $error("first pin mismatch");
  wmark_set_a: assert property (@(posedge mclk) disable iff (!nrst)
    evt_watermark |=> irq_event_flags[`MEPC_I_WMARK])
    else $error("fill level event lost");
  tap_mask_a: assert property (@(posedge mclk) disable iff (!nrst)
    wr && reg_addr == `MEPC_A_TAP |=> tap_axis_select == ($past(reg_wdata) & `MEPC_M_TAP))
    else $error("tap axis write wrong");
  standby_a: assert property (@(posedge mclk) disable iff (!nrst)
    !ctl.measure |=> !act_run && !inact_run && !fifo_wr_en)
    else $error("detectors running in standby");
  flag_hold_a: assert property (@(posedge mclk) disable iff (!nrst)
    !src_rd && !data_read |=> (irq_event_flags & $past(irq_event_flags)) == $past(irq_event_flags))
    else $error("flag cleared without read");
endmodule // mepc_regs

// >>> common/mepc_map.svh
// Purpose: Offsets, field positions, reset values and timing of the register slice
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef MEPC_MAP_SVH
`define MEPC_MAP_SVH
// ----------------------------------------
// Offsets
// ----------------------------------------
`define MEPC_A_FALL 8'h29
`define MEPC_A_TAP 8'h2a
`define MEPC_A_EVST 8'h2b
`define MEPC_A_RATE 8'h2c
`define MEPC_A_PWR 8'h2d
`define MEPC_A_IEN 8'h2e
`define MEPC_A_IMAP 8'h2f
`define MEPC_A_ISRC 8'h30
`define MEPC_A_FMT 8'h31
// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define MEPC_RST_ZERO 8'h00
`define MEPC_RST_RATE 8'h0a
`define MEPC_M_TAP 8'h0f
`define MEPC_M_RATE 8'h1f
`define MEPC_M_PWR 8'h3f
`define MEPC_M_FMT 8'hef
`define MEPC_M_FIFO 8'h83
`define MEPC_M_DET 8'h7c
`define MEPC_RANGE_16G 2'h3
// ----------------------------------------
// Interrupt bit positions
// ----------------------------------------
`define MEPC_I_READY 7
`define MEPC_I_SINGLE 6
`define MEPC_I_DOUBLE 5
`define MEPC_I_ACT 4
`define MEPC_I_INACT 3
`define MEPC_I_FALL 2
`define MEPC_I_WMARK 1
`define MEPC_I_OVR 0
// ----------------------------------------
// Other field positions
// ----------------------------------------
`define MEPC_TAP_SUPP 3
`define MEPC_LOW_PWR 4
`define MEPC_PWR_LINK 5
`define MEPC_PWR_AUTO 4
`define MEPC_PWR_MEAS 3
`define MEPC_PWR_SLEEP 2
`define MEPC_FMT_TEST 7
`define MEPC_FMT_INV 5
`define MEPC_ST_ASLEEP 3
// ----------------------------------------
// Timing
// ----------------------------------------
`define MEPC_CLK_NS 40
`define MEPC_NS_PER_MS 1000000
`define MEPC_FALL_STEP_MS 5
`define MEPC_WAKE_BASE_MS 125
`endif

// >>> common/mepc_pkg.sv
// Purpose: Types shared by the register slice
// Assumes: Nothing
// Notes: One-hot link states
package mepc_pkg;
  typedef enum logic [2:0] {
    lk_free = 3'h1,
    lk_seek_inact = 3'h2,
    lk_seek_act = 3'h4
  } mepc_link_t;
endpackage

// >>> common/mepc_ctl_if.sv
// Purpose: Signals between the register slice and its timing helpers
// Assumes: Single clock
// Notes: Top drives configuration and accepted events
`timescale 1ns/10ps
interface mepc_ctl_if;
  logic fall_below;
  logic [7:0] fall_code;
  logic fall_evt;
  logic measure;
  logic link_en;
  logic auto_sleep;
  logic sleep_req;
  logic [1:0] wake_code;
  logic act_fn_en;
  logic inact_fn_en;
  logic act_hit;
  logic inact_hit;
  logic act_run;
  logic inact_run;
  logic asleep;
  logic awake;
  logic doze_tick;
  modport top (output fall_below, fall_code, measure, link_en, auto_sleep, sleep_req, wake_code,
    act_fn_en, inact_fn_en, act_hit, inact_hit,
    input fall_evt, act_run, inact_run, asleep, awake, doze_tick);
  modport fall (input fall_below, fall_code, awake, output fall_evt);
  modport pwr (input measure, link_en, auto_sleep, sleep_req, wake_code, act_fn_en, inact_fn_en,
    act_hit, inact_hit, output act_run, inact_run, asleep, awake, doze_tick);
endinterface

// >>> rtl/mepc_fall_timer.sv
// Purpose: Weightless duration qualifier in 5 ms steps
// Assumes: fall_below is the RSS-below-threshold level
// Notes: Fires once per below episode
`timescale 1ns/10ps
module mepc_fall_timer #(
  parameter int STEP_CYC = 125000
) (
  input wire logic mclk,
  input wire logic nrst,
  mepc_ctl_if.fall ctl
);
  logic [23:0] pre, next_pre;
  logic [7:0] steps, next_steps;
  logic done, next_done;
  logic fire, next_fire;
  logic run;

  assign run = ctl.fall_below & ctl.awake;
  assign ctl.fall_evt = fire;

  always_comb begin
    next_pre = '0;
    next_steps = '0;
    next_done = 1'b0;
    next_fire = 1'b0;
    if (run) begin
      next_done = done;
      next_steps = steps;
      next_pre = (pre == 24'(STEP_CYC - 1)) ? '0 : pre + 24'h1;
      if (pre == 24'(STEP_CYC - 1) && steps != 8'hff)
        next_steps = steps + 8'h1;
      // Once the episode reaches the duration it fires one pulse
      if (!done && steps >= ctl.fall_code) begin
        next_fire = 1'b1;
        next_done = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre <= '0;
      steps <= '0;
      done <= 1'b0;
      fire <= 1'b0;
    end else begin
      pre <= next_pre;
      steps <= next_steps;
      done <= next_done;
      fire <= next_fire;
    end
  end

  fall_long_a: assert property (@(posedge mclk) disable iff (!nrst)
    fire |-> $past(run) && $past(steps) >= $past(ctl.fall_code))
    else $error("weightless event before duration");
  fall_gap_a: assert property (@(posedge mclk) disable iff (!nrst)
    !run |=> !fire)
    else $error("weightless event without fall level");
endmodule // mepc_fall_timer

// >>> rtl/mepc_power_state_control.sv
// Purpose: Linked activity/inactivity, automatic doze and wake-up rate
// Assumes: act_hit and inact_hit are accepted events
// Notes: Doze period doubles per wake-up code
`timescale 1ns/10ps
module mepc_power_state_control #(
  parameter int WAKE_CYC = 3125000
) (
  input wire logic mclk,
  input wire logic nrst,
  mepc_ctl_if.pwr ctl
);
  mepc_pkg::mepc_link_t st, next_st;
  logic asleep, next_asleep, act_run, next_act_run, inact_run, next_inact_run;
  logic awake, next_awake, tick, next_tick, link_on, dozing;
  logic [25:0] cnt, next_cnt, period;

  assign link_on = ctl.link_en & ctl.act_fn_en & ctl.inact_fn_en;
  assign period = 26'(WAKE_CYC) << ctl.wake_code;
  assign dozing = ctl.measure & (ctl.sleep_req | asleep);
  assign ctl.asleep = asleep;
  assign ctl.act_run = act_run;
  assign ctl.inact_run = inact_run;
  assign ctl.awake = awake;
  assign ctl.doze_tick = tick;

  always_comb begin
    next_st = st;
    next_asleep = asleep;
    unique case (st)
      mepc_pkg::lk_free: if (link_on) next_st = mepc_pkg::lk_seek_inact;
      mepc_pkg::lk_seek_inact: if (ctl.inact_hit) next_st = mepc_pkg::lk_seek_act;
      mepc_pkg::lk_seek_act: if (ctl.act_hit) next_st = mepc_pkg::lk_seek_inact;
    endcase
    if (!link_on)
      next_st = mepc_pkg::lk_free;
    if (!(link_on & ctl.auto_sleep & ctl.measure))
      next_asleep = 1'b0;
    else if (st == mepc_pkg::lk_seek_inact && ctl.inact_hit)
      next_asleep = 1'b1;
    else if (ctl.act_hit)
      next_asleep = 1'b0;
    next_act_run = ctl.measure & (next_st != mepc_pkg::lk_seek_inact);
    // In sleep only activity detection keeps running
    next_inact_run = ctl.measure & ~ctl.sleep_req & ~next_asleep & (next_st != mepc_pkg::lk_seek_act);
    next_awake = ctl.measure & ~ctl.sleep_req & ~next_asleep;
    next_cnt = '0;
    next_tick = 1'b0;
    if (dozing) begin
      next_tick = (cnt >= period - 26'h1);
      next_cnt = next_tick ? '0 : cnt + 26'h1;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= mepc_pkg::lk_free;
      asleep <= 1'b0;
      act_run <= 1'b0;
      inact_run <= 1'b0;
      awake <= 1'b0;
      cnt <= '0;
      tick <= 1'b0;
    end else begin
      st <= next_st;
      asleep <= next_asleep;
      act_run <= next_act_run;
      inact_run <= next_inact_run;
      awake <= next_awake;
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end

  sequence found_still;
    st == mepc_pkg::lk_seek_inact && ctl.inact_hit && link_on && ctl.auto_sleep && ctl.measure;
  endsequence
  doze_entry_a: assert property (@(posedge mclk) disable iff (!nrst)
    found_still |=> asleep && !awake)
    else $error("no doze after stillness");
  link_block_a: assert property (@(posedge mclk) disable iff (!nrst)
    st == mepc_pkg::lk_seek_inact && link_on |-> !act_run || $past(st) != mepc_pkg::lk_seek_inact)
    else $error("activity ran while waiting for stillness");
  no_auto_a: assert property (@(posedge mclk) disable iff (!nrst)
    !ctl.auto_sleep |=> !asleep)
    else $error("doze without automatic doze bit");
endmodule // mepc_power_state_control

// >>> verification/mepc_host_model.sv
// Purpose: Host processor side of the register port
// Assumes: One byte per strobe, strobes one cycle wide
// Notes: Idle address and data lines show the inverse of the last value
`timescale 1ns/10ps
module mepc_host_model (
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  output logic data_read
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    data_read = 1'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge mclk);
    #1;
    reg_wr = 1'h0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Answer is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge mclk);
    #1;
    reg_rd = 1'h0;
    reg_addr = ~a;
    @(posedge mclk);
    #1;
    d = reg_rdata;
  endtask
  // Axis data read; waits out the two cycles until the pins follow
  task automatic dread();
    @(posedge mclk);
    #1;
    data_read = 1'h1;
    @(posedge mclk);
    #1;
    data_read = 1'h0;
    repeat (2) @(posedge mclk);
    #1;
  endtask
endmodule // mepc_host_model

// >>> verification/tb.sv
// Purpose: Self-checking bench of the register slice
// Assumes: Short step counts through parameters
// Notes: Detector events are driven as one-cycle pulses
`timescale 1ns/10ps
module tb;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic [6:0] ev = 7'h00;
  logic knock_between_above = 1'h0;
  logic fall_below = 1'h0;
  logic [2:0] tap_axis_hit = 3'h7;
  logic [2:0] act_axis_hit = 3'h5;
  logic [2:0] act_axis_en = 3'h7;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
  logic reg_wr, reg_rd, data_read, irq_pin_a, irq_pin_b, double_knock_reject, low_power, measure;
  logic act_run, inact_run, fifo_wr_en, doze_tick, self_test, clip_en;
  logic [2:0] tap_axis_en;
  logic [3:0] rate_code;
  logic [23:0] wt [7] = '{24'h29_1414, 24'h2aff_0f, 24'h2bff_00, 24'h2cff_1f, 24'h2dc8_08, 24'h30ff_00,
    24'h31d3_c3};
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int nt;
  always #20 mclk = ~mclk;
  // Whole run needs well under a thousand cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      close_out();
    end
  end
  mepc_regs #(.FALL_STEP_CYC(4), .WAKE_CYC(8)) uut (.mclk, .nrst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .data_read, .evt_sample(ev[6]), .evt_watermark(ev[1]), .evt_overrun(ev[0]),
    .evt_single_tap(ev[5]), .evt_double_tap(ev[4]), .knock_between_above, .tap_axis_hit,
    .evt_activity(ev[3]), .act_axis_hit, .act_axis_en, .evt_inactivity(ev[2]), .fall_below, .irq_pin_a,
    .irq_pin_b, .tap_axis_en, .double_knock_reject, .low_power, .rate_code, .measure, .act_run, .inact_run,
    .fifo_wr_en, .doze_tick, .self_test, .clip_en);
  mepc_host_model host (.mclk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .data_read);
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk($sformatf("reg %h", a), v, e);
  endtask
  // Pulse taken at the second edge, pins settle one edge later
  task automatic pulse(input logic [6:0] m);
    @(posedge mclk);
    #1;
    ev = m;
    @(posedge mclk);
    #1;
    ev = 7'h00;
    @(posedge mclk);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    nrst = 1'h1;
    chk("rst", {irq_pin_a, irq_pin_b, rate_code, clip_en, measure}, 8'h2a);
    for (int a = 8'h29; a <= 8'h31; a++) rchk(a[7:0], (a == 8'h2c) ? 8'h0a : 8'h00);
    rchk(8'h40, 8'h00);
    $display("reset test done");
    for (int i = 0; i < 7; i++) host.wr(wt[i][23:16], wt[i][15:8]);
    for (int i = 0; i < 7; i++) rchk(wt[i][23:16], wt[i][7:0]);
    chk("cfg", {tap_axis_en, double_knock_reject, low_power, measure, self_test, clip_en}, 8'hfe);
    chk("rate", {4'h0, rate_code}, 8'h0f);
    host.wr(8'h2a, 8'h0e);
    host.wr(8'h2e, 8'h61);
    host.wr(8'h2f, 8'h01);
    $display("register test done");
    pulse(7'h03);
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h01);
    host.dread();
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h00);
    pulse(7'h40);
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h00);
    rchk(8'h30, 8'h80);
    rchk(8'h30, 8'h80);
    host.dread();
    rchk(8'h30, 8'h00);
    pulse(7'h20);
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h02);
    rchk(8'h2b, 8'h06);
    rchk(8'h30, 8'h40);
    rchk(8'h30, 8'h00);
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h00);
    knock_between_above = 1'h1;
    pulse(7'h10);
    rchk(8'h30, 8'h00);
    knock_between_above = 1'h0;
    pulse(7'h10);
    rchk(8'h30, 8'h20);
    host.wr(8'h31, 8'h20);
    repeat (2) @(posedge mclk);
    #1;
    chk("pins", {6'h00, irq_pin_a, irq_pin_b}, 8'h03);
    host.wr(8'h31, 8'h00);
    $display("interrupt test done");
    host.wr(8'h2e, 8'h18);
    pulse(7'h08);
    rchk(8'h2b, 8'h56);
    act_axis_en = 3'h3;
    act_axis_hit = 3'h7;
    pulse(7'h08);
    rchk(8'h2b, 8'h36);
    rchk(8'h30, 8'h10);
    host.wr(8'h2d, 8'h00);
    host.wr(8'h2d, 8'h38);
    pulse(7'h08);
    rchk(8'h30, 8'h00);
    chk("run", {6'h00, act_run, inact_run}, 8'h01);
    pulse(7'h04);
    rchk(8'h2b, 8'h3e);
    rchk(8'h30, 8'h08);
    chk("sleep", {6'h00, fifo_wr_en, act_run}, 8'h01);
    pulse(7'h40);
    rchk(8'h30, 8'h00);
    // Wake codes 0 and 1; the settle wait lets the new period take over
    for (int w = 0; w < 2; w++) begin
      host.wr(8'h2d, 8'h38 | w[7:0]);
      repeat (16) @(posedge mclk);
      nt = 0;
      repeat (64) begin
        @(posedge mclk);
        #1;
        nt += int'(doze_tick === 1'h1);
      end
      chk("doze", nt[7:0], 8'h08 >> w);
    end
    $display("power test done");
    host.wr(8'h2d, 8'h00);
    host.wr(8'h2d, 8'h08);
    host.wr(8'h29, 8'h14);
    host.wr(8'h2e, 8'h04);
    fall_below = 1'h1;
    rchk(8'h30, 8'h00);
    // Twenty steps of four cycles: still quiet one read before the event lands
    repeat (74) @(posedge mclk);
    rchk(8'h30, 8'h00);
    @(posedge mclk);
    rchk(8'h30, 8'h04);
    fall_below = 1'h0;
    $display("fall test done");
    close_out();
  end
endmodule // tb
